/* logic/pbt_core.sv */
// prbs bit error tester: link-side checker and system-side counters
`timescale 1ns/1ps
module pbt_core
  import pbt_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire logic i_stop,
  input wire pbt_link_cfg_t i_link_cfg,
  input wire logic [31:0] i_data_bit_limit,
  input wire logic [31:0] i_error_bit_limit,
  input wire logic i_bit_clk,
  input wire logic i_bit_data,
  input wire logic i_gate_input,
  input wire logic i_rerun_pulse_input,
  output logic o_running,
  output logic o_finished,
  output logic [31:0] o_data_count,
  output logic [31:0] o_error_count,
  output logic [31:0] o_rate_data,
  output logic [31:0] o_rate_err,
  output logic o_rate_nan,
  output logic o_clk_active,
  output logic o_data_active,
  output logic o_synced
);

  // ---------------- link clock domain ----------------
  typedef struct packed {
    pbt_link_cfg_t cfg1;
    pbt_link_cfg_t cfg2;
    logic pos_data;
    logic pos_gate;
    logic pos_rerun;
    logic [PBT_HIST_W-1:0] hist;
    logic [4:0] fill;
    logic prev_bit;
    logic rerun_prev;
    logic tgl;
    pbt_bit_evt_t evt;
  } pbt_link_st_t;

  localparam pbt_link_st_t PBT_LINK_ST_RST = '{
    cfg1: PBT_LINK_CFG_RST,
    cfg2: PBT_LINK_CFG_RST,
    hist: '0,
    fill: '0,
    evt: PBT_EVT_RST,
    default: 1'b0
  };

  pbt_link_st_t lk_r;
  pbt_link_st_t lk_nxt;
  logic lk_rst1_r;
  logic lk_rst2_r;
  logic neg_data_r;
  logic neg_gate_r;
  logic neg_rerun_r;

  // reset brought into the link domain; link clock may stall outside frames
  always_ff @(posedge i_bit_clk) begin
    lk_rst1_r <= i_resetn;
    lk_rst2_r <= lk_rst1_r;
  end

  // falling-edge capture, consumed at the following rising edge
  always_ff @(negedge i_bit_clk) begin
    neg_data_r <= i_bit_data;
    neg_gate_r <= i_gate_input;
    neg_rerun_r <= i_rerun_pulse_input;
  end

  always_comb begin
    logic smp_data;
    logic smp_gate;
    logic smp_rerun;
    logic rx_bit;
    logic gate_ok;
    logic halt;
    logic restart;
    logic expect_bit;
    logic [4:0] len;
    smp_data = 1'b0;
    smp_gate = 1'b0;
    smp_rerun = 1'b0;
    rx_bit = 1'b0;
    gate_ok = 1'b0;
    halt = 1'b0;
    restart = 1'b0;
    expect_bit = 1'b0;
    len = pbt_order_len(lk_r.cfg2.order);
    lk_nxt = lk_r;
    lk_nxt.cfg1 = i_link_cfg;
    lk_nxt.cfg2 = lk_r.cfg1;
    lk_nxt.pos_data = i_bit_data;
    lk_nxt.pos_gate = i_gate_input;
    lk_nxt.pos_rerun = i_rerun_pulse_input;
    if (lk_r.cfg2.edge_fall) begin
      smp_data = neg_data_r;
      smp_gate = neg_gate_r;
      smp_rerun = neg_rerun_r;
    end else begin
      smp_data = lk_r.pos_data;
      smp_gate = lk_r.pos_gate;
      smp_rerun = lk_r.pos_rerun;
    end
    rx_bit = smp_data ^ lk_r.cfg2.flipped_polarity;
    case (lk_r.cfg2.gate_input_mode)
      PBT_GATE_OFF: gate_ok = 1'b1;
      PBT_GATE_HIGH: gate_ok = smp_gate;
      PBT_GATE_LOW: gate_ok = !smp_gate;
      default: gate_ok = 1'b1;
    endcase
    // pin restart: halted while high, comparison restarts on the falling edge
    if (lk_r.cfg2.rerun_pin_mode) begin
      halt = smp_rerun;
      restart = lk_r.rerun_prev && !smp_rerun;
    end
    lk_nxt.rerun_prev = smp_rerun;
    lk_nxt.evt = PBT_EVT_RST;
    lk_nxt.evt.changed = rx_bit != lk_r.prev_bit;
    lk_nxt.prev_bit = rx_bit;
    lk_nxt.evt.rerun = restart;
    if (restart) begin
      // the bit under the falling pin opens the new sequence, so keep it
      lk_nxt.fill = '0;
      if (gate_ok) begin
        lk_nxt.evt.counted = 1'b1;
        lk_nxt.hist = {lk_r.hist[PBT_HIST_W-2:0], rx_bit};
        lk_nxt.fill = 5'h01;
      end
    end else if (gate_ok && !halt) begin
      // gated bits do not enter the history, so the sequence stays aligned
      expect_bit = ^(lk_r.hist & pbt_tap_mask(lk_r.cfg2.order));
      lk_nxt.evt.counted = 1'b1;
      lk_nxt.evt.err = (lk_r.fill == len) && (rx_bit != expect_bit);
      lk_nxt.hist = {lk_r.hist[PBT_HIST_W-2:0], rx_bit};
      if (lk_r.fill != len) begin
        lk_nxt.fill = lk_r.fill + 5'h01;
      end
    end
    lk_nxt.tgl = !lk_r.tgl;
    if (!lk_rst2_r) begin
      lk_nxt = PBT_LINK_ST_RST;
    end
  end

  always_ff @(posedge i_bit_clk) begin
    lk_r <= lk_nxt;
  end

  // ---------------- system clock domain ----------------
  typedef enum {
    PBT_IDLE,
    PBT_RUN
  } pbt_run_t;

  typedef struct packed {
    logic [3:0] tsync;
    pbt_bit_evt_t evt1;
    pbt_bit_evt_t evt2;
    pbt_run_t st;
    logic [31:0] dcnt;
    logic [31:0] ecnt;
    logic [31:0] fin_d;
    logic [31:0] fin_e;
    logic have_final;
    logic finished;
    logic clk_act;
    logic data_act;
    logic [31:0] rate_d;
    logic [31:0] rate_e;
    logic nan;
    logic synced;
  } pbt_sys_st_t;

  localparam pbt_sys_st_t PBT_SYS_ST_RST = '{
    tsync: '0,
    evt1: PBT_EVT_RST,
    evt2: PBT_EVT_RST,
    st: PBT_IDLE,
    dcnt: '0,
    ecnt: '0,
    fin_d: '0,
    fin_e: '0,
    rate_d: '0,
    rate_e: '0,
    nan: 1'b1,
    default: 1'b0
  };

  pbt_sys_st_t s_r;
  pbt_sys_st_t s_nxt;

  always_comb begin
    logic bit_evt;
    logic [31:0] d_new;
    logic [31:0] e_new;
    logic [35:0] err_x10;
    bit_evt = 1'b0;
    d_new = '0;
    e_new = '0;
    err_x10 = '0;
    s_nxt = s_r;
    // toggle crosses in four stages, payload in two; payload is settled
    // a cycle before the event fires. link clock must be well below mclk/4
    s_nxt.tsync = {s_r.tsync[2:0], lk_r.tgl};
    s_nxt.evt1 = lk_r.evt;
    s_nxt.evt2 = s_r.evt1;
    bit_evt = s_r.tsync[3] ^ s_r.tsync[2];
    case (s_r.st)
      PBT_IDLE: begin
        if (i_start) begin
          s_nxt.st = PBT_RUN;
          s_nxt.dcnt = '0;
          s_nxt.ecnt = '0;
          s_nxt.have_final = 1'b0;
          s_nxt.finished = 1'b0;
          s_nxt.clk_act = 1'b0;
          s_nxt.data_act = 1'b0;
        end
      end
      PBT_RUN: begin
        if (i_start) begin
          s_nxt.dcnt = '0;
          s_nxt.ecnt = '0;
          s_nxt.have_final = 1'b0;
          s_nxt.finished = 1'b0;
          s_nxt.clk_act = 1'b0;
          s_nxt.data_act = 1'b0;
        end else if (i_stop) begin
          s_nxt.st = PBT_IDLE;
          s_nxt.finished = 1'b1;
        end else if (bit_evt) begin
          s_nxt.clk_act = 1'b1;
          if (s_r.evt2.changed) begin
            s_nxt.data_act = 1'b1;
          end
          // a pin restart leaves the counts alone so results add up
          d_new = s_r.dcnt + {31'h0, s_r.evt2.counted};
          e_new = s_r.ecnt + {31'h0, s_r.evt2.err};
          s_nxt.dcnt = d_new;
          s_nxt.ecnt = e_new;
          if ((d_new >= i_data_bit_limit) || (e_new >= i_error_bit_limit)) begin
            s_nxt.finished = 1'b1;
            s_nxt.fin_d = d_new;
            s_nxt.fin_e = e_new;
            s_nxt.have_final = 1'b1;
            // new interval begins at once; the sequence repeats seamlessly
            s_nxt.dcnt = '0;
            s_nxt.ecnt = '0;
          end
        end
      end
      default: s_nxt.st = PBT_IDLE;
    endcase
    if (s_r.have_final) begin
      s_nxt.rate_d = s_r.fin_d;
      s_nxt.rate_e = s_r.fin_e;
    end else begin
      s_nxt.rate_d = s_r.dcnt;
      s_nxt.rate_e = s_r.ecnt;
    end
    s_nxt.nan = !s_r.have_final && (s_r.dcnt == 32'h0);
    err_x10 = {4'h0, s_r.rate_e} * {32'h0, PBT_SYNC_RATIO};
    s_nxt.synced = s_r.clk_act && s_r.data_act && (err_x10 < {4'h0, s_r.rate_d});
    if (!i_resetn) begin
      s_nxt = PBT_SYS_ST_RST;
    end
  end

  always_ff @(posedge i_mclk) begin
    s_r <= s_nxt;
  end

  assign o_running = s_r.st == PBT_RUN;
  assign o_finished = s_r.finished;
  assign o_data_count = s_r.dcnt;
  assign o_error_count = s_r.ecnt;
  assign o_rate_data = s_r.rate_d;
  assign o_rate_err = s_r.rate_e;
  assign o_rate_nan = s_r.nan;
  assign o_clk_active = s_r.clk_act;
  assign o_data_active = s_r.data_act;
  assign o_synced = s_r.synced;

endmodule

/* logic/pbt_pkg.sv */
// package of types and constants for the prbs bit error tester
package pbt_pkg;

  typedef enum logic [2:0] {
    PBT_PRBS9,
    PBT_PRBS11,
    PBT_PRBS15,
    PBT_PRBS16,
    PBT_PRBS20,
    PBT_PRBS21,
    PBT_PRBS23
  } pbt_order_t;

  typedef enum logic [1:0] {
    PBT_GATE_OFF,
    PBT_GATE_HIGH,
    PBT_GATE_LOW
  } pbt_gate_t;

  localparam int PBT_HIST_W = 23;
  localparam logic [31:0] PBT_DATA_BIT_LIMIT_DEF = 32'h0000_2710;
  localparam logic [31:0] PBT_DATA_BIT_LIMIT_MAX = 32'hFFFF_FFFE;
  localparam logic [31:0] PBT_ERROR_BIT_LIMIT_DEF = 32'h0000_0064;
  localparam logic [3:0] PBT_SYNC_RATIO = 4'hA;

  // settings that the link-clock logic needs
  typedef struct packed {
    logic edge_fall;
    logic flipped_polarity;
    pbt_gate_t gate_input_mode;
    pbt_order_t order;
    logic rerun_pin_mode;
  } pbt_link_cfg_t;

  localparam pbt_link_cfg_t PBT_LINK_CFG_RST = '{
    edge_fall: 1'b0,
    flipped_polarity: 1'b0,
    gate_input_mode: PBT_GATE_OFF,
    order: PBT_PRBS9,
    rerun_pin_mode: 1'b0
  };

  // one report per link clock edge
  typedef struct packed {
    logic counted;
    logic err;
    logic changed;
    logic rerun;
  } pbt_bit_evt_t;

  localparam pbt_bit_evt_t PBT_EVT_RST = '{default: 1'b0};

  // feedback taps, bit k stands for the bit received k+1 bits ago
  function automatic logic [PBT_HIST_W-1:0] pbt_tap_mask(input pbt_order_t ord);
    case (ord)
      PBT_PRBS9: pbt_tap_mask = 23'h00_0110;
      PBT_PRBS11: pbt_tap_mask = 23'h00_0500;
      PBT_PRBS15: pbt_tap_mask = 23'h00_6000;
      PBT_PRBS16: pbt_tap_mask = 23'h00_B400;
      PBT_PRBS20: pbt_tap_mask = 23'h08_0004;
      PBT_PRBS21: pbt_tap_mask = 23'h14_0000;
      PBT_PRBS23: pbt_tap_mask = 23'h42_0000;
      default: pbt_tap_mask = 23'h00_0110;
    endcase
  endfunction

  function automatic logic [4:0] pbt_order_len(input pbt_order_t ord);
    case (ord)
      PBT_PRBS9: pbt_order_len = 5'h09;
      PBT_PRBS11: pbt_order_len = 5'h0B;
      PBT_PRBS15: pbt_order_len = 5'h0F;
      PBT_PRBS16: pbt_order_len = 5'h10;
      PBT_PRBS20: pbt_order_len = 5'h14;
      PBT_PRBS21: pbt_order_len = 5'h15;
      PBT_PRBS23: pbt_order_len = 5'h17;
      default: pbt_order_len = 5'h09;
    endcase
  endfunction

endpackage

/* tb/pbt_core_assertions.sv */
// port checks for the prbs bit error tester
`timescale 1ns/1ps
module pbt_core_chk (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic [31:0] i_data_bit_limit,
  input wire logic [31:0] i_error_bit_limit,
  input wire logic o_running,
  input wire logic o_finished,
  input wire logic [31:0] o_data_count,
  input wire logic [31:0] o_error_count,
  input wire logic o_clk_active,
  input wire logic o_data_active,
  input wire logic o_synced
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  chk_start_opens: assert property (
    i_start |=> o_running && !o_finished && o_data_count == 32'h0) else $error("start failed");
  chk_stop_halts: assert property (
    i_stop && !i_start && o_running |=> !o_running && o_finished) else $error("stop failed");
  chk_idle_stop: assert property (
    i_stop && !i_start && !o_running |=> !o_running && $stable(o_finished))
    else $error("idle stop acted");
  chk_data_below: assert property (
    o_running |-> o_data_count < i_data_bit_limit) else $error("data limit passed");
  chk_err_below: assert property (
    o_running |-> o_error_count < i_error_bit_limit) else $error("error limit passed");
  chk_end_flag: assert property (
    o_running && $past(o_running) && !$past(i_start) && o_data_count == 32'h0
      && $past(o_data_count) != 32'h0 |-> o_finished) else $error("end unflagged");
  // one bit at a time, since the link runs far slower than mclk
  chk_count_step: assert property (
    o_running && $past(o_running) && !$past(i_start) && $changed(o_data_count)
      |-> o_data_count == $past(o_data_count) + 32'h1 || o_data_count == 32'h0)
    else $error("count jumped");
  chk_sync_flags: assert property (
    o_synced |-> $past(o_clk_active) && $past(o_data_active)) else $error("sync unfounded");
endmodule

bind pbt_core pbt_core_chk u_chk (.*);

/* tb/pbt_far_model.sv */
// far-side model: bit clock, prbs9 stream, gate and restart pin
`timescale 1ns/1ps
module pbt_far_model (
  output logic o_bit_clk,
  output logic o_bit_data,
  output logic o_gate,
  output logic o_rerun
);
  logic [8:0] seq_r;
  initial begin
    seq_r = 9'h1FF;
    o_bit_clk = 1'b0;
    o_bit_data = 1'b0;
    o_gate = 1'b0;
    o_rerun = 1'b0;
  end
  // clock stands still between frames; in falling mode the rise sees the inverse of the data the fall sees
  task automatic send(input int n, input int bad, input logic gate, input logic rr,
                      input logic fall, input logic flip);
    logic v;
    #0.7;
    for (int k = 0; k < n + rr; k++) begin
      o_rerun = rr && k == 0;
      o_gate = gate;
      v = seq_r[8] ^ seq_r[4];
      seq_r = o_rerun ? 9'h1FF : {seq_r[7:0], v};
      v = v ^ flip ^ (k == bad);
      o_bit_data = v ^ fall;
      #31.25 o_bit_clk = 1'b1;
      #31.25 o_bit_data = v;
      #31.25 o_bit_clk = 1'b0;
      #31.25;
    end
    o_rerun = 1'b0;
    o_bit_data = ~o_bit_data;
  endtask
endmodule

/* tb/tb_top.sv */
// self-checking bench for the prbs bit error tester
`timescale 1ns/1ps
module tb_top
  import pbt_pkg::*;
;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_start = 1'b0;
  logic i_stop = 1'b0;
  pbt_link_cfg_t cfg = PBT_LINK_CFG_RST;
  logic [31:0] dlim = PBT_DATA_BIT_LIMIT_DEF;
  logic [31:0] elim = PBT_ERROR_BIT_LIMIT_DEF;
  logic bclk, bdat, gate, rerun, run_o, fin, nan, cact, dact, sync_o;
  logic [31:0] dcnt, ecnt, rdat, rerr, c0, c1;
  int bad_count = 0;
  int comparisons = 0;

  always #2.5 i_mclk = ~i_mclk;

  pbt_core u_dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_start(i_start), .i_stop(i_stop),
    .i_link_cfg(cfg), .i_data_bit_limit(dlim), .i_error_bit_limit(elim), .i_bit_clk(bclk),
    .i_bit_data(bdat), .i_gate_input(gate), .i_rerun_pulse_input(rerun), .o_running(run_o),
    .o_finished(fin), .o_data_count(dcnt), .o_error_count(ecnt), .o_rate_data(rdat),
    .o_rate_err(rerr), .o_rate_nan(nan), .o_clk_active(cact), .o_data_active(dact),
    .o_synced(sync_o));
  pbt_far_model u_far (.o_bit_clk(bclk), .o_bit_data(bdat), .o_gate(gate), .o_rerun(rerun));

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic pulse(input logic st);
    @(negedge i_mclk);
    if (st) i_start = 1'b1;
    else i_stop = 1'b1;
    @(negedge i_mclk);
    i_start = 1'b0;
    i_stop = 1'b0;
    repeat (2) @(negedge i_mclk);
  endtask

  // counts land some mclk cycles after the last evaluating link edge
  task automatic run(input int n, input int bad, input logic g, input logic rr);
    u_far.send(n, bad, g, rr, cfg.edge_fall, cfg.flipped_polarity);
    repeat (12) @(negedge i_mclk);
  endtask

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #100000;
    bad_count++;
    $display("BAD watchdog expected done seen hang");
    conclude();
  end

  initial begin
    // link reset needs running bit clock, so reset outlasts a few link edges
    u_far.send(4, -1, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (6) @(negedge i_mclk);
    i_resetn = 1'b1;
    @(negedge i_mclk);
    check("reset state", 32'h1, {29'h0, fin, run_o, nan});
    // link reset leaves on bit clock edges; flush its stale bit from the history
    u_far.send(16, -1, 1'b0, 1'b0, 1'b0, 1'b0);
    dlim = 32'h28;
    pulse(1'b1);
    run(50, -1, 1'b0, 1'b0);
    check("finished", 32'h1, {31'h0, fin});
    check("final data", 32'h28, rdat);
    check("final errors", 32'h0, rerr);
    check("self restart", 32'h1, {31'h0, run_o});
    check("flags", 32'h7, {29'h0, cact, dact, sync_o});
    $display("test data limit done");
    pulse(1'b0);
    check("stopped", 32'h2, {30'h0, fin, run_o});
    pulse(1'b0);
    check("idle stop", 32'h2, {30'h0, fin, run_o});
    elim = 32'h3;
    dlim = 32'h3E8;
    pulse(1'b1);
    check("nan", 32'h1, {31'h0, nan});
    run(30, 12, 1'b0, 1'b0);
    check("final errors", 32'h3, rerr);
    check("fresh errors", 32'h0, ecnt);
    $display("test error limit done");
    elim = 32'hFFFF_FFFF;
    dlim = PBT_DATA_BIT_LIMIT_MAX;
    for (int m = 0; m < 3; m++) begin
      pulse(1'b0);
      cfg.gate_input_mode = pbt_gate_t'(m);
      pulse(1'b1);
      run(5, -1, m != 2, 1'b0);
      c0 = dcnt;
      run(20, -1, m == 2, 1'b0);
      check("gated count", c0 + (m == 0 ? 32'h14 : 32'h1), dcnt);
      run(20, -1, m != 2, 1'b0);
      check("open count", c0 + (m == 0 ? 32'h28 : 32'h14), dcnt);
    end
    $display("test gate done");
    pulse(1'b0);
    cfg.gate_input_mode = PBT_GATE_OFF;
    cfg.edge_fall = 1'b1;
    cfg.flipped_polarity = 1'b1;
    pulse(1'b1);
    run(20, -1, 1'b0, 1'b0);
    c0 = ecnt;
    run(40, -1, 1'b0, 1'b0);
    check("fall flip errors", c0, ecnt);
    $display("test edge polarity done");
    pulse(1'b0);
    cfg = PBT_LINK_CFG_RST;
    cfg.rerun_pin_mode = 1'b1;
    pulse(1'b1);
    run(20, -1, 1'b0, 1'b0);
    c0 = dcnt;
    c1 = ecnt;
    run(30, -1, 1'b0, 1'b1);
    check("accumulated", c0 + 32'h1E, dcnt);
    check("rerun errors", c1, ecnt);
    $display("test pin restart done");
    conclude();
  end
endmodule
